// ==== src/ldc_regs.vh ====
// register offsets, field positions and reset values of the led driver config bank
`ifndef LDC_REGS_VH
`define LDC_REGS_VH
`define LDC_ADDR_REVISION     8'h00
`define LDC_ADDR_SOFT_RESET   8'h01
`define LDC_ADDR_SINK_ASSIGN  8'h10
`define LDC_ADDR_A_ONOFF_RAMP 8'h11
`define LDC_ADDR_B_ONOFF_RAMP 8'h12
`define LDC_ADDR_RT_RAMP      8'h13
`define LDC_ADDR_RT_SELECT    8'h14
`define LDC_ADDR_RESERVED     8'h15
`define LDC_ADDR_DIMMING      8'h16
`define LDC_ADDR_A_FULLSCALE  8'h17
`define LDC_ADDR_B_FULLSCALE  8'h18
`define LDC_ADDR_FEEDBACK     8'h19
`define LDC_ADDR_BOOST        8'h1a
`define LDC_ADDR_AUTO_FREQ    8'h1b
`define LDC_ADDR_PWM_SETUP    8'h1c
`define LDC_ADDR_A_LEVEL_LOW  8'h20
`define LDC_ADDR_A_LEVEL_HIGH 8'h21
`define LDC_ADDR_B_LEVEL_LOW  8'h22
`define LDC_ADDR_B_LEVEL_HIGH 8'h23
`define LDC_ADDR_BANK_ON      8'h24
`define LDC_ADDR_OPEN_FLAGS   8'hb0
`define LDC_ADDR_SHORT_FLAGS  8'hb2
`define LDC_ADDR_FAULT_ARM    8'hb4
`define LDC_RST_SINK_ASSIGN   3'h6
`define LDC_RST_RAMP          8'h00
`define LDC_RST_RT_SELECT     4'h0
`define LDC_RST_RESERVED      8'h33
`define LDC_RST_DIMMING       3'h0
`define LDC_RST_FULLSCALE     5'h13
`define LDC_RST_FEEDBACK      3'h7
`define LDC_RST_BOOST         5'h00
`define LDC_RST_AUTO_FREQ     8'hcf
`define LDC_RST_PWM_SETUP     4'hc
`define LDC_RST_LEVEL_LOW     3'h0
`define LDC_RST_LEVEL_HIGH    8'h00
`define LDC_RST_BANK_ON       2'h0
`define LDC_RST_FAULT_ARM     2'h0
`define LDC_SOFT_RESET_BIT    0
`define LDC_DIM_LINEAR_BIT    0
`define LDC_DIM_A_NODITHER    1
`define LDC_DIM_B_NODITHER    2
`define LDC_BOOST_FREQ_BIT    0
`define LDC_BOOST_OVP_LSB     1
`define LDC_BOOST_AFREQ_BIT   3
`define LDC_BOOST_AHR_BIT     4
`define LDC_PWM_A_BIT         0
`define LDC_PWM_B_BIT         1
`define LDC_PWM_POL_BIT       2
`define LDC_PWM_ZERO_BIT      3
`define LDC_ARM_OPEN_BIT      0
`define LDC_ARM_SHORT_BIT     1
`endif

// ==== src/ldc_led_driver_config_registers.v ====
// configuration and status register bank of a three-string led driver
//
// Function
// - soft reset bit resets device, self-clears
// - revision reads fixed four-bit code
// - per-sink bank routing, default 0x06
// - per-bank shutdown and startup ramp codes
// - shared runtime ramp up/down codes
// - per-bank runtime ramp source select
// - mapping mode exponential or linear
// - per-bank dither disable bits
// - per-bank five-bit full-scale current code
// - per-sink feedback enable, default all ones
// - boost frequency select bit
// - two-bit overvoltage threshold select
// - auto headroom and auto frequency enables
// - auto frequency threshold, reset 0xcf
// - pwm scaling enables and polarity
// - pwm zero-duty detection enable
// - brightness code from low and high registers
// - high write commits code, starts ramp
// - bank enable bits, default off
// - fault flags readable when armed
// - all resets restore config defaults; read port clears on rst only
// - address and data byte arrive together in one strobe
`timescale 1ns/1ns
`default_nettype none
`include "ldc_regs.vh"

module ldc_led_driver_config_registers #(
  parameter [3:0] SILICON_REV = 4'h5 // arbitrary value
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  input  wire        hardware_enable_pin,
  // register access from the serial slave
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // fault sensing from the analog side
  input  wire [2:0]  sense_open,
  input  wire [2:0]  sense_short,
  // configuration toward the analog and dimming engines
  output wire        soft_reset_pulse,
  output wire [2:0]  sink_to_bank_b,
  output wire [3:0]  bank_a_startup_code,
  output wire [3:0]  bank_a_shutdown_code,
  output wire [3:0]  bank_b_startup_code,
  output wire [3:0]  bank_b_shutdown_code,
  output wire [3:0]  ramp_up_code,
  output wire [3:0]  ramp_down_code,
  output wire [1:0]  bank_a_ramp_select,
  output wire [1:0]  bank_b_ramp_select,
  output wire        linear_mapping,
  output wire        bank_a_dither_off,
  output wire        bank_b_dither_off,
  output wire [4:0]  bank_a_fs_code,
  output wire [4:0]  bank_b_fs_code,
  output wire [2:0]  sink_feedback_on,
  output wire        boost_freq_1mhz,
  output wire [1:0]  overvoltage_threshold,
  output wire        auto_freq_on,
  output wire        auto_headroom_on,
  output wire [7:0]  auto_freq_threshold,
  output wire        pwm_bank_a_on,
  output wire        pwm_bank_b_on,
  output wire        pwm_active_high,
  output wire        pwm_zero_detect_on,
  output reg  [10:0] bank_a_level,
  output reg  [10:0] bank_b_level,
  output reg         bank_a_ramp_start,
  output reg         bank_b_ramp_start,
  output wire [1:0]  bank_on,
  output wire        open_detect_on,
  output wire        short_detect_on
);

  reg       soft_reset;
  reg [2:0] sink_assign;
  reg [7:0] a_onoff;
  reg [7:0] b_onoff;
  reg [7:0] rt_ramp;
  reg [3:0] rt_select;
  reg [2:0] dimming;
  reg [4:0] a_fs;
  reg [4:0] b_fs;
  reg [2:0] feedback;
  reg [4:0] boost;
  reg [7:0] auto_freq;
  reg [3:0] pwm_setup;
  reg [2:0] a_low;
  reg [7:0] a_high;
  reg [2:0] b_low;
  reg [7:0] b_high;
  reg [1:0] bank_en;
  reg [1:0] fault_arm;
  reg [2:0] open_flags;
  reg [2:0] short_flags;
  reg [7:0] next_rdata;

  // any reset source returns every config and flag register to its default; read data and valid clear on rst only
  wire reg_reset = rst | soft_reset | ~hardware_enable_pin;

  // one write strobe for all addresses; data byte arrives with the address in the same cycle
  wire wr_sel_hit = reg_wr;

  // high-byte writes commit a bank's code
  wire wr_a_high = wr_sel_hit && reg_addr == `LDC_ADDR_A_LEVEL_HIGH;
  wire wr_b_high = wr_sel_hit && reg_addr == `LDC_ADDR_B_LEVEL_HIGH;

  always @(posedge core_clk) begin
    if (rst | ~hardware_enable_pin) begin
      soft_reset <= 1'b0;
    end else if (soft_reset) begin
      soft_reset <= 1'b0;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_SOFT_RESET) begin
      soft_reset <= reg_wdata[`LDC_SOFT_RESET_BIT];
    end
  end

  // one process per register; unmapped addresses touch nothing
  always @(posedge core_clk) begin
    if (reg_reset) begin
      sink_assign <= `LDC_RST_SINK_ASSIGN;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_SINK_ASSIGN) begin
      sink_assign <= reg_wdata[2:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      a_onoff <= `LDC_RST_RAMP;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_A_ONOFF_RAMP) begin
      a_onoff <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      b_onoff <= `LDC_RST_RAMP;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_B_ONOFF_RAMP) begin
      b_onoff <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      rt_ramp <= `LDC_RST_RAMP;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_RT_RAMP) begin
      rt_ramp <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      rt_select <= `LDC_RST_RT_SELECT;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_RT_SELECT) begin
      rt_select <= reg_wdata[3:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      dimming <= `LDC_RST_DIMMING;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_DIMMING) begin
      dimming <= {reg_wdata[3:2], reg_wdata[0]};
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      a_fs <= `LDC_RST_FULLSCALE;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_A_FULLSCALE) begin
      a_fs <= reg_wdata[4:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      b_fs <= `LDC_RST_FULLSCALE;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_B_FULLSCALE) begin
      b_fs <= reg_wdata[4:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      feedback <= `LDC_RST_FEEDBACK;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_FEEDBACK) begin
      feedback <= reg_wdata[2:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      boost <= `LDC_RST_BOOST;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_BOOST) begin
      boost <= reg_wdata[4:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      auto_freq <= `LDC_RST_AUTO_FREQ;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_AUTO_FREQ) begin
      auto_freq <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      pwm_setup <= `LDC_RST_PWM_SETUP;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_PWM_SETUP) begin
      pwm_setup <= reg_wdata[3:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      a_low <= `LDC_RST_LEVEL_LOW;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_A_LEVEL_LOW) begin
      a_low <= reg_wdata[2:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      a_high <= `LDC_RST_LEVEL_HIGH;
    end else if (wr_a_high) begin
      a_high <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      b_low <= `LDC_RST_LEVEL_LOW;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_B_LEVEL_LOW) begin
      b_low <= reg_wdata[2:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      b_high <= `LDC_RST_LEVEL_HIGH;
    end else if (wr_b_high) begin
      b_high <= reg_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      bank_en <= `LDC_RST_BANK_ON;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_BANK_ON) begin
      bank_en <= reg_wdata[1:0];
    end
  end

  always @(posedge core_clk) begin
    if (reg_reset) begin
      fault_arm <= `LDC_RST_FAULT_ARM;
    end else if (wr_sel_hit && reg_addr == `LDC_ADDR_FAULT_ARM) begin
      fault_arm <= reg_wdata[1:0];
    end
  end

  // low byte stays pending; high write commits the combined code
  always @(posedge core_clk) begin
    if (reg_reset) begin
      bank_a_level      <= 11'h000;
      bank_b_level      <= 11'h000;
      bank_a_ramp_start <= 1'b0;
      bank_b_ramp_start <= 1'b0;
    end else begin
      bank_a_ramp_start <= wr_a_high;
      bank_b_ramp_start <= wr_b_high;
      if (wr_a_high) begin
        bank_a_level <= {reg_wdata, a_low};
      end
      if (wr_b_high) begin
        bank_b_level <= {reg_wdata, b_low};
      end
    end
  end

  // flags follow the sensors only while armed
  always @(posedge core_clk) begin
    if (reg_reset) begin
      open_flags  <= 3'h0;
      short_flags <= 3'h0;
    end else begin
      open_flags  <= fault_arm[`LDC_ARM_OPEN_BIT] ? sense_open : 3'h0;
      short_flags <= fault_arm[`LDC_ARM_SHORT_BIT] ? sense_short : 3'h0;
    end
  end

  always @* begin
    case (reg_addr)
      `LDC_ADDR_REVISION:     next_rdata = {4'h0, SILICON_REV};
      `LDC_ADDR_SOFT_RESET:   next_rdata = 8'h00;
      `LDC_ADDR_SINK_ASSIGN:  next_rdata = {5'h00, sink_assign};
      `LDC_ADDR_A_ONOFF_RAMP: next_rdata = a_onoff;
      `LDC_ADDR_B_ONOFF_RAMP: next_rdata = b_onoff;
      `LDC_ADDR_RT_RAMP:      next_rdata = rt_ramp;
      `LDC_ADDR_RT_SELECT:    next_rdata = {4'h0, rt_select};
      `LDC_ADDR_RESERVED:     next_rdata = `LDC_RST_RESERVED;
      `LDC_ADDR_DIMMING:      next_rdata = {4'h0, dimming[2:1], 1'b0, dimming[0]};
      `LDC_ADDR_A_FULLSCALE:  next_rdata = {3'h0, a_fs};
      `LDC_ADDR_B_FULLSCALE:  next_rdata = {3'h0, b_fs};
      `LDC_ADDR_FEEDBACK:     next_rdata = {5'h00, feedback};
      `LDC_ADDR_BOOST:        next_rdata = {3'h0, boost};
      `LDC_ADDR_AUTO_FREQ:    next_rdata = auto_freq;
      `LDC_ADDR_PWM_SETUP:    next_rdata = {4'h0, pwm_setup};
      `LDC_ADDR_A_LEVEL_LOW:  next_rdata = {5'h00, a_low};
      `LDC_ADDR_A_LEVEL_HIGH: next_rdata = a_high;
      `LDC_ADDR_B_LEVEL_LOW:  next_rdata = {5'h00, b_low};
      `LDC_ADDR_B_LEVEL_HIGH: next_rdata = b_high;
      `LDC_ADDR_BANK_ON:      next_rdata = {6'h00, bank_en};
      `LDC_ADDR_OPEN_FLAGS:   next_rdata = {5'h00, open_flags};
      `LDC_ADDR_SHORT_FLAGS:  next_rdata = {5'h00, short_flags};
      `LDC_ADDR_FAULT_ARM:    next_rdata = {6'h00, fault_arm};
      default:                next_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  assign soft_reset_pulse      = soft_reset;
  assign sink_to_bank_b        = sink_assign;
  assign bank_a_startup_code   = a_onoff[3:0];
  assign bank_a_shutdown_code  = a_onoff[7:4];
  assign bank_b_startup_code   = b_onoff[3:0];
  assign bank_b_shutdown_code  = b_onoff[7:4];
  assign ramp_up_code          = rt_ramp[7:4];
  assign ramp_down_code        = rt_ramp[3:0];
  assign bank_a_ramp_select    = rt_select[1:0];
  assign bank_b_ramp_select    = rt_select[3:2];
  assign linear_mapping        = dimming[`LDC_DIM_LINEAR_BIT];
  assign bank_a_dither_off     = dimming[`LDC_DIM_A_NODITHER];
  assign bank_b_dither_off     = dimming[`LDC_DIM_B_NODITHER];
  assign bank_a_fs_code        = a_fs;
  assign bank_b_fs_code        = b_fs;
  assign sink_feedback_on      = feedback;
  assign boost_freq_1mhz       = boost[`LDC_BOOST_FREQ_BIT];
  assign overvoltage_threshold = boost[2:1];
  assign auto_freq_on          = boost[`LDC_BOOST_AFREQ_BIT];
  assign auto_headroom_on      = boost[`LDC_BOOST_AHR_BIT];
  assign auto_freq_threshold   = auto_freq;
  assign pwm_bank_a_on         = pwm_setup[`LDC_PWM_A_BIT];
  assign pwm_bank_b_on         = pwm_setup[`LDC_PWM_B_BIT];
  assign pwm_active_high       = pwm_setup[`LDC_PWM_POL_BIT];
  assign pwm_zero_detect_on    = pwm_setup[`LDC_PWM_ZERO_BIT];
  assign bank_on               = bank_en;
  assign open_detect_on        = fault_arm[`LDC_ARM_OPEN_BIT];
  assign short_detect_on       = fault_arm[`LDC_ARM_SHORT_BIT];

endmodule
`default_nettype wire

// ==== tb/ldc_regs_chk.sv ====
// concurrent checks on the ports of the led driver config register bank
`timescale 1ns/1ns
`default_nettype none
module ldc_regs_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        hardware_enable_pin,
  // register strobes
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rvalid,
  // configuration outputs
  input wire logic        soft_reset_pulse,
  input wire logic [2:0]  sink_to_bank_b,
  input wire logic [1:0]  overvoltage_threshold,
  input wire logic        boost_freq_1mhz,
  input wire logic        auto_freq_on,
  input wire logic        auto_headroom_on,
  input wire logic [7:0]  auto_freq_threshold,
  input wire logic        linear_mapping,
  input wire logic        bank_a_dither_off,
  input wire logic        bank_b_dither_off,
  input wire logic [10:0] bank_a_level,
  input wire logic        bank_a_ramp_start,
  input wire logic [1:0]  bank_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // write that lands, outside any reset
  sequence wr_to(logic [7:0] a);
    reg_wr && reg_addr == a && hardware_enable_pin && !soft_reset_pulse;
  endsequence
  sequence one_pulse;
    soft_reset_pulse ##1 !soft_reset_pulse;
  endsequence
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without valid");
  soft_pulse_a: assert property (wr_to(8'h01) ##0 reg_wdata[0] |=> one_pulse)
    else $error("soft reset pulse wrong");
  soft_defaults_a: assert property (soft_reset_pulse |=> sink_to_bank_b == 3'h6
    && overvoltage_threshold == 2'h0 && auto_freq_threshold == 8'hcf)
    else $error("soft reset left config");
  hw_defaults_a: assert property (!hardware_enable_pin |=> sink_to_bank_b == 3'h6
    && bank_on == 2'h0 && auto_freq_threshold == 8'hcf)
    else $error("enable pin low left config");
  level_commit_a: assert property (wr_to(8'h21) |=> bank_a_ramp_start
    && bank_a_level[10:3] == $past(reg_wdata))
    else $error("high byte did not commit");
  low_pending_a: assert property (wr_to(8'h20) |=> $stable(bank_a_level)
    && !bank_a_ramp_start)
    else $error("low byte changed level");
  boost_fields_a: assert property (wr_to(8'h1a) |=> {3'h0, auto_headroom_on,
    auto_freq_on, overvoltage_threshold, boost_freq_1mhz} == ($past(reg_wdata) & 8'h1f))
    else $error("boost fields wrong");
  dim_fields_a: assert property (wr_to(8'h16) |=> {4'h0, bank_b_dither_off,
    bank_a_dither_off, 1'b0, linear_mapping} == ($past(reg_wdata) & 8'h0d))
    else $error("dimming fields wrong");
  sink_route_a: assert property (wr_to(8'h10) |=> {5'h0, sink_to_bank_b}
    == ($past(reg_wdata) & 8'h07))
    else $error("sink routing wrong");
endmodule
bind ldc_led_driver_config_registers ldc_regs_chk ldc_regs_chk_i (.core_clk, .rst,
  .hardware_enable_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .soft_reset_pulse,
  .sink_to_bank_b, .overvoltage_threshold, .boost_freq_1mhz, .auto_freq_on, .auto_headroom_on,
  .auto_freq_threshold, .linear_mapping, .bank_a_dither_off, .bank_b_dither_off, .bank_a_level,
  .bank_a_ramp_start, .bank_on);
`default_nettype wire

// ==== tb/ldc_host_model.sv ====
// host side model issuing register strobes
`timescale 1ns/1ns
`default_nettype none
module ldc_host_model (
  // clock
  input  wire logic       core_clk,
  // register strobes
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // address and data travel together for one strobe cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released bus shows garbage, not the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ==== tb/ldc_led_driver_config_registers_bench.sv ====
// self-checking bench of the led driver config register bank
`timescale 1ns/1ns
`default_nettype none
module ldc_led_driver_config_registers_bench;
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam logic [183:0] AD = 184'h00_10_11_12_13_14_15_16_17_18_19_1a_1b_1c_20_21_22_23_24_b4_b0_b2_30;
  localparam logic [183:0] DV = {4'h0, REV, 176'h06_00_00_00_00_33_00_13_13_07_00_cf_0c_00_00_00_00_00_00_00_00_00};
  localparam logic [183:0] MK = {4'h0, REV, 176'h07_ff_ff_ff_0f_33_0d_1f_1f_07_1f_ff_0f_07_ff_07_ff_03_03_00_00_00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hardware_enable_pin = 1'b1;
  logic [2:0] sense_open = 3'h0;
  logic [2:0] sense_short = 3'h0;
  wire reg_wr, reg_rd, reg_rvalid, soft_reset_pulse, linear_mapping, bank_a_dither_off;
  wire bank_b_dither_off, boost_freq_1mhz, auto_freq_on, auto_headroom_on;
  wire bank_a_ramp_start, bank_b_ramp_start;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire [2:0] sink_to_bank_b;
  wire [1:0] overvoltage_threshold, bank_on;
  wire [10:0] bank_a_level, bank_b_level;
  wire [3:0] bank_a_startup_code, bank_a_shutdown_code;
  wire [3:0] bank_b_startup_code, bank_b_shutdown_code;
  wire [3:0] ramp_up_code, ramp_down_code;
  wire [1:0] bank_a_ramp_select, bank_b_ramp_select;
  wire [4:0] bank_a_fs_code, bank_b_fs_code;
  wire [2:0] sink_feedback_on;
  wire [7:0] auto_freq_threshold;
  wire pwm_bank_a_on, pwm_bank_b_on, pwm_active_high, pwm_zero_detect_on;
  wire open_detect_on, short_detect_on;
  wire [63:0] cfg2 = {bank_a_shutdown_code, bank_a_startup_code, bank_b_shutdown_code,
    bank_b_startup_code, ramp_up_code, ramp_down_code, bank_b_ramp_select, bank_a_ramp_select,
    3'h0, bank_a_fs_code, 3'h0, bank_b_fs_code, 1'b0, sink_feedback_on, auto_freq_threshold,
    pwm_zero_detect_on, pwm_active_high, pwm_bank_b_on, pwm_bank_a_on, 2'h0, short_detect_on,
    open_detect_on};
  wire [15:0] cfg = {3'h0, linear_mapping, bank_a_dither_off, bank_b_dither_off,
    overvoltage_threshold, boost_freq_1mhz, auto_freq_on, auto_headroom_on, bank_on, sink_to_bank_b};
  wire [23:0] lv = {bank_b_ramp_start, bank_b_level, bank_a_ramp_start, bank_a_level};
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] exp_q [$];
  logic [7:0] e, d;
  logic [15:0] seed = 16'h26c7; // 9927
  ldc_host_model ldc_host_model_i (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ldc_led_driver_config_registers #(.SILICON_REV(REV)) ldc_led_driver_config_registers_i (
    .core_clk, .rst, .hardware_enable_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .sense_open, .sense_short, .soft_reset_pulse, .sink_to_bank_b,
    .bank_a_startup_code, .bank_a_shutdown_code, .bank_b_startup_code,
    .bank_b_shutdown_code, .ramp_up_code, .ramp_down_code, .bank_a_ramp_select,
    .bank_b_ramp_select, .linear_mapping, .bank_a_dither_off, .bank_b_dither_off,
    .bank_a_fs_code, .bank_b_fs_code, .sink_feedback_on, .boost_freq_1mhz,
    .overvoltage_threshold, .auto_freq_on, .auto_headroom_on, .auto_freq_threshold,
    .pwm_bank_a_on, .pwm_bank_b_on, .pwm_active_high, .pwm_zero_detect_on,
    .bank_a_level, .bank_b_level, .bank_a_ramp_start, .bank_b_ramp_start, .bank_on,
    .open_detect_on, .short_detect_on);
  always #2 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    ldc_host_model_i.xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    ldc_host_model_i.xfer(1'b0, a, 8'h00);
  endtask
  task automatic tbl(input logic [183:0] t);
    for (int i = 0; i < 23; i++)
      rd(AD[8*(22-i) +: 8], t[8*(22-i) +: 8]);
  endtask
  // read answers are matched against the oldest note
  always @(posedge core_clk) begin
    cyc++;
    if (reg_rvalid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    end
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    tbl(DV);
    for (int i = 0; i < 23; i++)
      wr(AD[8*(22-i) +: 8], 8'hff);
    tbl(MK);
    chk("cfg", 16'h1fff, cfg);
    chk("cfg2", 64'hffff_fff1_f1f7_fff3, cfg2);
    wr(8'h01, 8'h01);
    chk("soft_reset_pulse", 16'h0001, {15'h0, soft_reset_pulse});
    repeat (2) @(posedge core_clk);
    chk("cfg", 16'h0006, cfg);
    chk("cfg2", 64'h0000_0001_3137_cfc0, cfg2);
    tbl(DV);
    rd(8'h01, 8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      d = {seed[7:3], k[1:0], seed[0]};
      wr(8'h1a, d);
      chk("boost", {11'h0, d[4:0]}, {11'h0, auto_headroom_on, auto_freq_on, overvoltage_threshold, boost_freq_1mhz});
      rd(8'h1a, d & 8'h1f);
    end
    for (int b = 0; b < 2; b++) begin
      seed = lfsr(seed);
      wr(8'h20 + 8'(2*b), seed[7:0]);
      chk("level", 16'h0000, {4'h0, lv[12*b +: 12]});
      wr(8'h21 + 8'(2*b), seed[15:8]);
      chk("level", {4'h1, seed[15:8], seed[2:0], 1'b0} >> 1, {4'h0, lv[12*b +: 12]});
      wr(8'h20 + 8'(2*b), ~seed[7:0]);
      chk("level", {5'h0, seed[15:8], seed[2:0]}, {4'h0, lv[12*b +: 12]});
    end
    sense_open = 3'h5;
    sense_short = 3'h3;
    wr(8'hb4, 8'h01);
    rd(8'hb0, 8'h05);
    rd(8'hb2, 8'h00);
    wr(8'hb4, 8'h02);
    rd(8'hb0, 8'h00);
    rd(8'hb2, 8'h03);
    wr(8'h1b, 8'h12);
    hardware_enable_pin = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    hardware_enable_pin = 1'b1;
    rd(8'h1b, 8'hcf);
    repeat (4) @(posedge core_clk);
    chk("pending", 16'h0000, 16'(exp_q.size()));
    test_done();
  end
endmodule
`default_nettype wire
